/* File: inc/cfg_header_pkg.sv */
// Constants for the configuration header register bank
package cfg_header_pkg;
  // Register offsets within configuration space
  localparam logic [7:0] OFF_STATUS_CMD = 8'h04;
  localparam logic [7:0] OFF_CLASS_REV  = 8'h08;
  localparam logic [7:0] OFF_LINE_LAT   = 8'h0c;
  localparam logic [7:0] OFF_BASE_LOW   = 8'h10;

  // Status and command bit positions
  localparam int BIT_PARITY_SEEN   = 31;
  localparam int BIT_SYSERR_SENT   = 30;
  localparam int BIT_GOT_MABORT    = 29;
  localparam int BIT_GOT_TABORT    = 28;
  localparam int BIT_SENT_TABORT   = 27;
  localparam int BIT_SEL_TIMING_HI = 26;
  localparam int BIT_SEL_TIMING_LO = 25;
  localparam int BIT_MASTER_PARITY = 24;
  localparam int BIT_FAST_B2B      = 23;
  localparam int BIT_SPEED_66      = 21;
  localparam int BIT_CAP_LIST      = 20;
  localparam int BIT_SYSERR_EN     = 8;
  localparam int BIT_PARITY_EN     = 6;
  localparam int BIT_INITIATOR_EN  = 2;
  localparam int BIT_MEMSPACE_EN   = 1;
  localparam int BIT_IOSPACE_EN    = 0;

  // Medium select timing code
  localparam logic [1:0] SEL_TIMING_MEDIUM = 2'h1;

  // Class code and header values
  localparam logic [7:0] BASE_CLASS_VAL = 8'h06;
  localparam logic [7:0] SUB_CLASS_VAL  = 8'h80;
  localparam logic [7:0] PROG_IF_VAL    = 8'h00;
  localparam logic [7:0] HEADER_VAL     = 8'h00;
  // Silicon revision, value arbitrary
  localparam logic [7:0] SILICON_REV    = 8'h2a;

  // Cache line size and latency timer values
  localparam logic [7:0] CACHE_LINE_OK      = 8'h08;
  localparam logic [7:0] CACHE_LINE_RST     = 8'h00;
  localparam logic [7:0] LAT_RST_CONV       = 8'h00;
  localparam logic [7:0] LAT_RST_PCIX       = 8'h40;
  localparam logic [7:0] LAT_GRAIN_MASK     = 8'hf8;

  // Base address word layout
  localparam int         BASE_LSB      = 12;
  localparam logic [3:0] BASE_LOW_BITS = 4'h4;
  localparam logic [19:0] BASE_RST     = 20'h00000;
endpackage

/* File: hdl/cfg_header_regs.sv */
// Configuration header register bank with status, command and base decode
`timescale 1ns/1ps
// How it works
// RULE1 - Parity error sets bit 31 regardless of parity enable; write one clears.
// RULE2 - Driving SYS_ERROR_REPORT_EN sets bit 30; write one clears, zero ignored.
// RULE3 - Own transaction master-abort, not special cycle, sets bit 29; write one clears.
// RULE4 - Own transaction target-abort sets bit 28; write one clears.
// RULE5 - Never signals target-abort; bit 27 reads zero.
// RULE6 - Select timing bits 26:25 report fixed medium timing.
// RULE7 - Bit 24 set on PARITY_RESPONSE_EN seen, own transfer, parity enabled; write one clears.
// RULE8 - SYS_ERROR_REPORT_EN driven only with bit 8 set, upon system error.
// RULE9 - PARITY_RESPONSE_EN driven only with bit 6 set, upon data parity error.
// RULE10 - Starts transactions only while bit 2 is set.
// RULE11 - Claims memory hits only while bit 1 is set.
// RULE12 - I/O enable bit 0 fixed zero; never answers I/O space.
// RULE13 - Fast back-to-back bit 23 reads one in PCI, zero in PCI-X.
// RULE14 - 66 MHz capable bit 21 always reads one.
// RULE15 - Capabilities list bit 20 always reads one.
// RULE16 - Class fields read 0x06, 0x80, 0x00 whatever is written.
// RULE17 - Bits 7:0 of class word report the silicon revision.
// RULE18 - Cache line size keeps 0x08 when written, else stores 0x00.
// RULE19 - After grant loss in a burst, stays owner at most timer clocks; ownerExpired rises after timer+1 clocks.
// RULE20 - Latency timer in 8-clock steps; resets 0x00 PCI, 0x40 PCI-X.
// RULE21 - Header type reads 0x00.
// RULE22 - Software writes base bits 31:12; device decodes memory there.
// RULE23 - Base word low bits read memory type 10b, not prefetchable, memory.
// RULE24 - Base bits 11:4 read zero, giving a 4 KiB window.
module cfg_header_regs (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Bus mode strap pin, high in PCI-X mode
  input  wire logic        pcixModePin,
  // Configuration access port
  input  wire logic        cfgRead,
  input  wire logic        cfgWrite,
  input  wire logic [7:0]  cfgOffset,
  input  wire logic [3:0]  cfgByteEn,
  input  wire logic [31:0] cfgWdata,
  output logic      [31:0] cfgRdata,
  output logic             cfgAck,
  // Error events from bus logic
  input  wire logic        parityErrDetected,
  input  wire logic        dataParityErr,
  input  wire logic        perrObserved,
  input  wire logic        masterOfTransfer,
  input  wire logic        sysErrDetected,
  input  wire logic        masterAbortRcvd,
  input  wire logic        specialCycle,
  input  wire logic        targetAbortRcvd,
  // Error pins, open drain
  output logic             serrOut,
  output logic             serrOe,
  output logic             perrOut,
  output logic             perrOe,
  // Initiator side
  input  wire logic        startRequest,
  output logic             startGrant,
  input  wire logic        burstActive,
  input  wire logic        busGrant,
  output logic             ownerExpired,
  // Target side memory decode
  input  wire logic        memCycle,
  input  wire logic        ioCycle,
  input  wire logic [31:0] memAddr,
  output logic             memClaim,
  output logic             ioClaim,
  output logic             busInitiatorEn,
  output logic             memorySpaceEn
);

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    LT_IDLE    = 3'b001,
    LT_COUNT   = 3'b010,
    LT_EXPIRED = 3'b100
  } latState_t;

  typedef struct packed {
    logic        modeMeta;
    logic        modeSync;
    logic        paritySeen;
    logic        sysErrSent;
    logic        gotMAbort;
    logic        gotTAbort;
    logic        masterParity;
    logic        sysErrEn;
    logic        parityEn;
    logic        initiatorEn;
    logic        memSpaceEn;
    logic [7:0]  cacheLine;
    logic [7:0]  latTimer;
    logic [19:0] base;
    logic [31:0] rdata;
    logic        ack;
    logic        serrOe;
    logic        perrOe;
    logic        grant;
    logic        claim;
    logic        ioClaim;
    logic        serrLevel;
    logic        perrLevel;
    latState_t   latState;
    logic [7:0]  latCnt;
    logic        expired;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge for a writable field
  function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Read value of a register
  function automatic logic [31:0] readWord(input state_t s, input logic [7:0] off);
    logic [31:0] w;
    w = 32'h00000000;
    if (off == cfg_header_pkg::OFF_STATUS_CMD) begin
      w[cfg_header_pkg::BIT_PARITY_SEEN]   = s.paritySeen;
      w[cfg_header_pkg::BIT_SYSERR_SENT]   = s.sysErrSent;
      w[cfg_header_pkg::BIT_GOT_MABORT]    = s.gotMAbort;
      w[cfg_header_pkg::BIT_GOT_TABORT]    = s.gotTAbort;
      w[cfg_header_pkg::BIT_SENT_TABORT]   = 1'b0; // RULE5
      w[cfg_header_pkg::BIT_SEL_TIMING_HI:cfg_header_pkg::BIT_SEL_TIMING_LO] =
        cfg_header_pkg::SEL_TIMING_MEDIUM; // RULE6
      w[cfg_header_pkg::BIT_MASTER_PARITY] = s.masterParity;
      w[cfg_header_pkg::BIT_FAST_B2B]      = ~s.modeSync; // RULE13
      w[cfg_header_pkg::BIT_SPEED_66]      = 1'b1; // RULE14
      w[cfg_header_pkg::BIT_CAP_LIST]      = 1'b1; // RULE15
      w[cfg_header_pkg::BIT_SYSERR_EN]     = s.sysErrEn;
      w[cfg_header_pkg::BIT_PARITY_EN]     = s.parityEn;
      w[cfg_header_pkg::BIT_INITIATOR_EN]  = s.initiatorEn;
      w[cfg_header_pkg::BIT_MEMSPACE_EN]   = s.memSpaceEn;
      w[cfg_header_pkg::BIT_IOSPACE_EN]    = 1'b0; // RULE12
    end else if (off == cfg_header_pkg::OFF_CLASS_REV) begin
      w = {cfg_header_pkg::BASE_CLASS_VAL, cfg_header_pkg::SUB_CLASS_VAL,
           cfg_header_pkg::PROG_IF_VAL, cfg_header_pkg::SILICON_REV}; // RULE16 RULE17
    end else if (off == cfg_header_pkg::OFF_LINE_LAT) begin
      w = {8'h00, cfg_header_pkg::HEADER_VAL, s.latTimer, s.cacheLine}; // RULE21
    end else if (off == cfg_header_pkg::OFF_BASE_LOW) begin
      w = {s.base, 8'h00, cfg_header_pkg::BASE_LOW_BITS}; // RULE23 RULE24
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic        wrStatus;
  logic        wrLine;
  logic        wrBase;
  logic [31:0] w1c;
  logic [31:0] statusNow;
  logic [31:0] cmdMerged;
  logic [31:0] lineMerged;
  logic [31:0] baseMerged;
  logic        mAbortEv;
  logic        perrEv;

  always_comb begin
    st_nxt     = st_r;
    wrStatus   = cfgWrite && (cfgOffset == cfg_header_pkg::OFF_STATUS_CMD);
    wrLine     = cfgWrite && (cfgOffset == cfg_header_pkg::OFF_LINE_LAT);
    wrBase     = cfgWrite && (cfgOffset == cfg_header_pkg::OFF_BASE_LOW);
    w1c        = (wrStatus && cfgByteEn[3]) ? cfgWdata : 32'h00000000;
    statusNow  = readWord(st_r, cfg_header_pkg::OFF_STATUS_CMD);
    cmdMerged  = laneMerge(statusNow, cfgWdata, cfgByteEn);
    lineMerged = laneMerge(readWord(st_r, cfg_header_pkg::OFF_LINE_LAT),
                           cfgWdata, cfgByteEn);
    baseMerged = laneMerge(readWord(st_r, cfg_header_pkg::OFF_BASE_LOW),
                           cfgWdata, cfgByteEn);
    mAbortEv   = masterAbortRcvd && !specialCycle;
    perrEv     = (perrObserved || (dataParityErr && st_r.parityEn)) &&
                 masterOfTransfer && st_r.parityEn;

    // Mode strap synchroniser
    st_nxt.modeMeta = pcixModePin;
    st_nxt.modeSync = st_r.modeMeta;

    // Error flags, a new event wins over a clear
    st_nxt.paritySeen   = (st_r.paritySeen & ~w1c[cfg_header_pkg::BIT_PARITY_SEEN]) |
                          parityErrDetected; // RULE1
    st_nxt.sysErrSent   = (st_r.sysErrSent & ~w1c[cfg_header_pkg::BIT_SYSERR_SENT]) |
                          (sysErrDetected & st_r.sysErrEn); // RULE2
    st_nxt.gotMAbort    = (st_r.gotMAbort & ~w1c[cfg_header_pkg::BIT_GOT_MABORT]) |
                          mAbortEv; // RULE3
    st_nxt.gotTAbort    = (st_r.gotTAbort & ~w1c[cfg_header_pkg::BIT_GOT_TABORT]) |
                          targetAbortRcvd; // RULE4
    st_nxt.masterParity = (st_r.masterParity & ~w1c[cfg_header_pkg::BIT_MASTER_PARITY]) |
                          perrEv; // RULE7

    if (wrStatus) begin
      st_nxt.sysErrEn    = cmdMerged[cfg_header_pkg::BIT_SYSERR_EN];
      st_nxt.parityEn    = cmdMerged[cfg_header_pkg::BIT_PARITY_EN];
      st_nxt.initiatorEn = cmdMerged[cfg_header_pkg::BIT_INITIATOR_EN];
      st_nxt.memSpaceEn  = cmdMerged[cfg_header_pkg::BIT_MEMSPACE_EN];
    end
    if (wrLine && cfgByteEn[0]) begin
      st_nxt.cacheLine = (cfgWdata[7:0] == cfg_header_pkg::CACHE_LINE_OK) ?
                         cfg_header_pkg::CACHE_LINE_OK :
                         cfg_header_pkg::CACHE_LINE_RST; // RULE18
    end
    if (wrLine) begin
      st_nxt.latTimer = lineMerged[15:8] & cfg_header_pkg::LAT_GRAIN_MASK; // RULE20
    end
    if (wrBase) begin
      st_nxt.base = baseMerged[31:cfg_header_pkg::BASE_LSB]; // RULE22
    end

    // Configuration answer one cycle after the request
    st_nxt.ack   = cfgRead || cfgWrite;
    st_nxt.rdata = cfgRead ? readWord(st_r, cfgOffset) : 32'h00000000;

    // Error pins
    st_nxt.serrOe = sysErrDetected && st_r.sysErrEn; // RULE8
    st_nxt.perrOe = dataParityErr && st_r.parityEn; // RULE9
    // Open drain pins only ever pull low
    st_nxt.serrLevel = 1'b0;
    st_nxt.perrLevel = 1'b0;

    // Initiator start and target claim
    st_nxt.grant = startRequest && st_r.initiatorEn; // RULE10
    st_nxt.claim = memCycle && st_r.memSpaceEn &&
                   (memAddr[31:cfg_header_pkg::BASE_LSB] == st_r.base); // RULE11 RULE22
    // I/O cycles gated by the hard-wired-off I/O enable
    st_nxt.ioClaim = ioCycle && statusNow[cfg_header_pkg::BIT_IOSPACE_EN]; // RULE12

    // Latency timer after grant loss
    st_nxt.expired = 1'b0;
    case (st_r.latState)
      LT_IDLE: begin
        if (burstActive && !busGrant) begin
          st_nxt.latCnt = st_r.latTimer;
          if (st_r.latTimer == 8'h00) begin
            st_nxt.latState = LT_EXPIRED;
            st_nxt.expired  = 1'b1;
          end else begin
            st_nxt.latState = LT_COUNT;
          end
        end
      end
      LT_COUNT: begin
        if (!burstActive || busGrant) begin
          st_nxt.latState = LT_IDLE;
        end else if (st_r.latCnt == 8'h01) begin
          st_nxt.latState = LT_EXPIRED; // RULE19
          st_nxt.expired  = 1'b1;
          st_nxt.latCnt   = 8'h00;
        end else begin
          st_nxt.latCnt = st_r.latCnt - 8'h01;
        end
      end
      LT_EXPIRED: begin
        st_nxt.expired = burstActive && !busGrant;
        if (!st_nxt.expired) begin
          st_nxt.latState = LT_IDLE;
        end
      end
      default: begin
        st_nxt.latState = LT_IDLE;
      end
    endcase

    if (sys_rst) begin
      st_nxt.paritySeen   = 1'b0;
      st_nxt.sysErrSent   = 1'b0;
      st_nxt.gotMAbort    = 1'b0;
      st_nxt.gotTAbort    = 1'b0;
      st_nxt.masterParity = 1'b0;
      st_nxt.sysErrEn     = 1'b0;
      st_nxt.parityEn     = 1'b0;
      st_nxt.initiatorEn  = 1'b0;
      st_nxt.memSpaceEn   = 1'b0;
      st_nxt.cacheLine    = cfg_header_pkg::CACHE_LINE_RST;
      st_nxt.latTimer     = st_r.modeSync ? cfg_header_pkg::LAT_RST_PCIX :
                                            cfg_header_pkg::LAT_RST_CONV; // RULE20
      st_nxt.base         = cfg_header_pkg::BASE_RST;
      st_nxt.rdata        = 32'h00000000;
      st_nxt.ack          = 1'b0;
      st_nxt.serrOe       = 1'b0;
      st_nxt.perrOe       = 1'b0;
      st_nxt.grant        = 1'b0;
      st_nxt.claim        = 1'b0;
      st_nxt.ioClaim      = 1'b0;
      st_nxt.serrLevel    = 1'b0;
      st_nxt.perrLevel    = 1'b0;
      st_nxt.latState     = LT_IDLE;
      st_nxt.latCnt       = 8'h00;
      st_nxt.expired      = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    st_r <= st_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign cfgRdata       = st_r.rdata;
  assign cfgAck         = st_r.ack;
  assign serrOut        = st_r.serrLevel;
  assign serrOe         = st_r.serrOe;
  assign perrOut        = st_r.perrLevel;
  assign perrOe         = st_r.perrOe;
  assign startGrant     = st_r.grant;
  assign ownerExpired   = st_r.expired;
  assign memClaim       = st_r.claim;
  assign ioClaim        = st_r.ioClaim;
  assign busInitiatorEn = st_r.initiatorEn;
  assign memorySpaceEn  = st_r.memSpaceEn;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence clearParity_s;
    cfgWrite && cfgOffset == cfg_header_pkg::OFF_STATUS_CMD && cfgByteEn[3] &&
    cfgWdata[cfg_header_pkg::BIT_PARITY_SEEN] && !parityErrDetected;
  endsequence

  parity_set_a: assert property (parityErrDetected |=> st_r.paritySeen) // RULE1
    else $error("parity flag not set");
  parity_clear_a: assert property (clearParity_s |=> !st_r.paritySeen) // RULE1
    else $error("parity flag not cleared");
  sys_error_report_en_flag_a: assert property (serrOe |-> st_r.sysErrSent) // RULE2
    else $error("sys_error_report_en driven without flag");
  mabort_a: assert property (masterAbortRcvd && !specialCycle |=> st_r.gotMAbort) // RULE3
    else $error("master abort flag missed");
  tabort_a: assert property (targetAbortRcvd |=> st_r.gotTAbort) // RULE4
    else $error("target abort flag missed");
  sys_error_report_en_gate_a: assert property (serrOe |-> $past(st_r.sysErrEn)) // RULE8
    else $error("sys_error_report_en driven while disabled");
  parity_response_en_gate_a: assert property (perrOe |-> $past(st_r.parityEn)) // RULE9
    else $error("parity_response_en driven while disabled");
  start_gate_a: assert property (startGrant |-> $past(st_r.initiatorEn)) // RULE10
    else $error("start while initiator disabled");
  claim_gate_a: assert property (memClaim |-> $past(st_r.memSpaceEn)) // RULE11
    else $error("claim while memory disabled");
  cache_line_a: assert property (st_r.cacheLine == 8'h00 || st_r.cacheLine == 8'h08) // RULE18
    else $error("illegal cache line value");
  lat_grain_a: assert property (st_r.latTimer[2:0] == 3'h0) // RULE20
    else $error("latency timer granularity broken");
  read_ack_a: assert property (cfgRead |=> cfgAck) // RULE16
    else $error("config read not answered");

  sequence readOf_s(logic [7:0] off);
    cfgRead && cfgOffset == off;
  endsequence

  sent_tabort_a: assert property (readOf_s(cfg_header_pkg::OFF_STATUS_CMD) |=> // RULE5
    !cfgRdata[cfg_header_pkg::BIT_SENT_TABORT])
    else $error("target abort bit set");
  sel_timing_a: assert property (readOf_s(cfg_header_pkg::OFF_STATUS_CMD) |=> // RULE6
    cfgRdata[cfg_header_pkg::BIT_SEL_TIMING_HI:cfg_header_pkg::BIT_SEL_TIMING_LO] ==
    cfg_header_pkg::SEL_TIMING_MEDIUM) else $error("select timing wrong");
  class_code_a: assert property (readOf_s(cfg_header_pkg::OFF_CLASS_REV) |=> // RULE16 RULE17
    cfgRdata == {cfg_header_pkg::BASE_CLASS_VAL, cfg_header_pkg::SUB_CLASS_VAL,
                 cfg_header_pkg::PROG_IF_VAL, cfg_header_pkg::SILICON_REV})
    else $error("class word wrong");
  header_type_a: assert property (readOf_s(cfg_header_pkg::OFF_LINE_LAT) |=> // RULE21
    cfgRdata[31:16] == {8'h00, cfg_header_pkg::HEADER_VAL})
    else $error("header type wrong");
  base_low_a: assert property (readOf_s(cfg_header_pkg::OFF_BASE_LOW) |=> // RULE23 RULE24
    cfgRdata[11:0] == {8'h00, cfg_header_pkg::BASE_LOW_BITS})
    else $error("base low bits wrong");
  mparity_a: assert property (perrObserved && masterOfTransfer && st_r.parityEn |=> // RULE7
    st_r.masterParity)
    else $error("master parity flag missed");
  io_claim_a: assert property (ioCycle |=> !ioClaim) // RULE12
    else $error("io cycle claimed");
endmodule

/* File: bench/cfg_host_model.sv */
// Host side model: configuration cycles and bus event stimulus
`timescale 1ns/1ps
module cfg_host_model (
  input  wire logic        core_clk,
  input  wire logic        cfgAck,
  input  wire logic [31:0] cfgRdata,
  output logic             cfgRead,
  output logic             cfgWrite,
  output logic      [7:0]  cfgOffset,
  output logic      [3:0]  cfgByteEn,
  output logic      [31:0] cfgWdata,
  output logic      [5:0]  events,
  output logic      [7:0]  levels,
  output logic      [31:0] memAddr
);
  initial begin
    {cfgRead, cfgWrite, cfgOffset, cfgByteEn, cfgWdata} = '0;
    {events, levels, memAddr} = '0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One access then an idle cycle; released data lines flip
  task automatic access(input logic wrt, input logic [7:0] off, input logic [3:0] be,
                        input logic [31:0] wd, output logic ack, output logic [31:0] rdat);
    cfgRead   = !wrt;
    cfgWrite  = wrt;
    cfgOffset = off;
    cfgByteEn = be;
    cfgWdata  = wd;
    @(posedge core_clk);
    #1;
    ack       = cfgAck;
    rdat      = cfgRdata;
    cfgRead   = 1'b0;
    cfgWrite  = 1'b0;
    cfgWdata  = ~wd;
    cfgOffset = ~off;
    @(posedge core_clk);
    #1;
  endtask
  task automatic pulse(input logic [5:0] m);
    events = m;
    @(posedge core_clk);
    #1;
    events = '0;
  endtask
  task automatic bus(input logic [7:0] lv, input logic [31:0] a);
    levels  = lv;
    memAddr = a;
  endtask
endmodule

/* File: bench/cfg_header_regs_tb.sv */
// Self-checking bench for the configuration header register bank
`timescale 1ns/1ps
module cfg_header_regs_tb;
  logic        core_clk, sys_rst, pm, cfgRead, cfgWrite, cfgAck;
  logic [7:0]  cfgOffset, levels;
  logic [3:0]  cfgByteEn;
  logic [5:0]  events;
  logic [31:0] cfgWdata, cfgRdata, memAddr, cmdv;
  logic        serrOe, perrOe, startGrant, ownerExpired, memClaim, ioClaim, initEn, memEn;
  logic        serrOut, perrOut;
  int          miscompares, totalChecks, n;
  logic [5:0]  evMask [6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h21};
  logic [31:0] flEn [6] = '{32'h80000000, 32'h40000000, 32'h20000000, 32'h10000000,
                            32'h01000000, 32'h81000000};
  logic [31:0] flDis [6] = '{32'h80000000, 32'h0, 32'h20000000, 32'h10000000, 32'h0,
                             32'h80000000};

  cfg_header_regs cfg_header_regs_inst (
    .core_clk, .sys_rst, .pcixModePin(levels[0]), .cfgRead, .cfgWrite, .cfgOffset,
    .cfgByteEn, .cfgWdata, .cfgRdata, .cfgAck, .parityErrDetected(events[0]),
    .dataParityErr(events[5]), .perrObserved(events[4]), .masterOfTransfer(levels[1]),
    .sysErrDetected(events[1]), .masterAbortRcvd(events[2]), .specialCycle(levels[7]),
    .targetAbortRcvd(events[3]), .serrOut, .serrOe, .perrOut, .perrOe,
    .startRequest(levels[2]), .startGrant, .burstActive(levels[3]), .busGrant(levels[4]),
    .ownerExpired, .memCycle(levels[5]), .ioCycle(levels[6]), .memAddr, .memClaim,
    .ioClaim, .busInitiatorEn(initEn), .memorySpaceEn(memEn));

  cfg_host_model cfg_host_model_inst (
    .core_clk, .cfgAck, .cfgRdata, .cfgRead, .cfgWrite, .cfgOffset, .cfgByteEn,
    .cfgWdata, .events, .levels, .memAddr);

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && totalChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  function automatic logic [31:0] stat(input logic [31:0] fl, input logic [31:0] cmd);
    stat = fl | cmd | 32'h00300000 | {5'h0, cfg_header_pkg::SEL_TIMING_MEDIUM, 25'h0};
    if (!pm)
      stat = stat | 32'h00800000;
  endfunction

  task automatic rd(input logic [7:0] off, input logic [31:0] exp);
    logic        ack;
    logic [31:0] d;
    cfg_host_model_inst.access(1'b0, off, 4'h0, 32'h0, ack, d);
    check("readAck", {31'h0, ack}, 32'h1);
    check("readData", d, exp);
  endtask

  task automatic wr(input logic [7:0] off, input logic [3:0] be, input logic [31:0] wd);
    logic        ack;
    logic [31:0] d;
    cfg_host_model_inst.access(1'b1, off, be, wd, ack, d);
    check("writeAck", {31'h0, ack}, 32'h1);
  endtask

  task automatic do_reset(input logic m);
    pm = m;
    sys_rst = 1'b1;
    @(posedge core_clk);
    #1;
    cfg_host_model_inst.bus({7'h0, m}, 32'h0);
    repeat (7) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(4000 * 50);
    miscompares++;
    give_verdict();
  end

  initial begin
    do_reset(1'b0);
    rd(8'h00, 32'h0);
    rd(cfg_header_pkg::OFF_STATUS_CMD, stat(32'h0, 32'h0));
    for (int i = 0; i < 2; i++) begin
      rd(cfg_header_pkg::OFF_CLASS_REV, {cfg_header_pkg::BASE_CLASS_VAL,
         cfg_header_pkg::SUB_CLASS_VAL, cfg_header_pkg::PROG_IF_VAL,
         cfg_header_pkg::SILICON_REV});
      wr(cfg_header_pkg::OFF_CLASS_REV, 4'hf, 32'hffffffff);
    end
    rd(cfg_header_pkg::OFF_LINE_LAT, {8'h00, cfg_header_pkg::HEADER_VAL, 16'h0000});
    wr(cfg_header_pkg::OFF_LINE_LAT, 4'hf, 32'hffffff08);
    rd(cfg_header_pkg::OFF_LINE_LAT, {16'h0000, 8'hf8, 8'h08});
    wr(cfg_header_pkg::OFF_LINE_LAT, 4'h1, 32'h00000010);
    rd(cfg_header_pkg::OFF_LINE_LAT, {16'h0000, 8'hf8, 8'h00});
    rd(cfg_header_pkg::OFF_BASE_LOW, 32'h00000004);
    wr(cfg_header_pkg::OFF_BASE_LOW, 4'hf, 32'hffffffff);
    rd(cfg_header_pkg::OFF_BASE_LOW, 32'hfffff004);
    wr(cfg_header_pkg::OFF_BASE_LOW, 4'hf, 32'h12345678);
    rd(cfg_header_pkg::OFF_BASE_LOW, 32'h12345004);
    for (int en = 0; en < 2; en++) begin
      cmdv = en ? 32'h00000146 : 32'h0;
      wr(cfg_header_pkg::OFF_STATUS_CMD, 4'h3, en ? 32'h0000ffff : 32'h0);
      rd(cfg_header_pkg::OFF_STATUS_CMD, stat(32'h0, cmdv));
      cfg_host_model_inst.bus(8'h66, 32'h12345ffc);
      @(posedge core_clk);
      #1;
      check("startGrant", {31'h0, startGrant}, 32'(en));
      check("memClaim", {31'h0, memClaim}, 32'(en));
      check("ioClaim", {31'h0, ioClaim}, 32'h0);
      check("enables", {30'h0, initEn, memEn}, en ? 32'h3 : 32'h0);
      cfg_host_model_inst.bus(8'h22, 32'h12346000);
      @(posedge core_clk);
      #1;
      check("memMiss", {31'h0, memClaim}, 32'h0);
      for (int i = 0; i < 6; i++) begin
        cfg_host_model_inst.pulse(evMask[i]);
        check("serrOe", {31'h0, serrOe}, 32'(en && i == 1));
        check("perrOe", {31'h0, perrOe}, 32'(en && i == 5));
        check("pinLevels", {30'h0, serrOut, perrOut}, 32'h0);
        rd(cfg_header_pkg::OFF_STATUS_CMD, stat(en ? flEn[i] : flDis[i], cmdv));
        wr(cfg_header_pkg::OFF_STATUS_CMD, 4'h8, 32'h0);
        rd(cfg_header_pkg::OFF_STATUS_CMD, stat(en ? flEn[i] : flDis[i], cmdv));
        wr(cfg_header_pkg::OFF_STATUS_CMD, 4'h8, 32'hff000000);
        rd(cfg_header_pkg::OFF_STATUS_CMD, stat(32'h0, cmdv));
      end
    end
    cfg_host_model_inst.bus(8'h82, 32'h0);
    cfg_host_model_inst.pulse(6'h04);
    rd(cfg_header_pkg::OFF_STATUS_CMD, stat(32'h0, cmdv));
    wr(cfg_header_pkg::OFF_LINE_LAT, 4'h2, 32'h00001000);
    cfg_host_model_inst.bus(8'h0a, 32'h0);
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (ownerExpired !== 1'b1 && n < 300);
    check("ownerCycles", 32'(n), 32'h11);
    cfg_host_model_inst.bus(8'h1a, 32'h0);
    @(posedge core_clk);
    #1;
    check("ownerRelease", {31'h0, ownerExpired}, 32'h0);
    wr(cfg_header_pkg::OFF_LINE_LAT, 4'h2, 32'h00000000);
    cfg_host_model_inst.bus(8'h0a, 32'h0);
    @(posedge core_clk);
    #1;
    check("ownerAtZero", {31'h0, ownerExpired}, 32'h1);
    do_reset(1'b1);
    rd(cfg_header_pkg::OFF_LINE_LAT, {8'h00, cfg_header_pkg::HEADER_VAL,
       cfg_header_pkg::LAT_RST_PCIX, 8'h00});
    rd(cfg_header_pkg::OFF_STATUS_CMD, stat(32'h0, 32'h0));
    rd(cfg_header_pkg::OFF_BASE_LOW, 32'h00000004);
    give_verdict();
  end
endmodule
